// file: test/rfsq_sequencer_sva.sv
// Purpose: port-level assertions of the frame sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: bound into every rfsq_sequencer instance
`timescale 1ns/1ps
`default_nettype none

module rfsq_sequencer_sva #(
  parameter int SETTLE_CYCLES = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // bus handshake
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // activity inputs
  input wire logic lowFreqReceiverActive,
  input wire logic sensorMeasureActive,
  input wire logic cpuActive,
  // outputs
  input wire rfsq_pkg::rfsq_rf_t rfOut,
  input wire logic mediumFreqOscEnable,
  input wire logic transmitIrq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [15:0] settleCnt;

  // ==========
  // cycles the crystal has been powered, saturating
  always_ff @(posedge sys_clk) begin
    if (reset || !rfOut.xtalPllEnable) begin
      settleCnt <= 16'h0000;
    end else if (settleCnt != 16'hFFFF) begin
      settleCnt <= settleCnt + 16'h0001;
    end
  end

  // ==========
  // assertions
  bus_answer_a: assert property ($rose(read || write) |->
    waitrequest ##1 waitrequest ##1 !waitrequest ##1 waitrequest) else $error("bus answer timing wrong");
  mfo_follow_a: assert property (
    (lowFreqReceiverActive || sensorMeasureActive || cpuActive) |=> mediumFreqOscEnable)
    else $error("medium clock not enabled by activity");
  mfo_xtal_a: assert property (rfOut.xtalPllEnable |-> mediumFreqOscEnable)
    else $error("medium clock off while transmitting");
  pa_xtal_a: assert property (rfOut.paEnable |-> rfOut.xtalPllEnable)
    else $error("amplifier on without crystal");
  settle_time_a: assert property ($rose(rfOut.paEnable) |-> settleCnt >= SETTLE_CYCLES)
    else $error("amplifier on before settle time");
  warm_bound_a: assert property ($rose(rfOut.xtalPllEnable) |-> ##[1:40] rfOut.paEnable)
    else $error("amplifier never followed crystal start");
  frame_end_a: assert property ($fell(rfOut.paEnable) |-> !rfOut.data)
    else $error("data left high at frame end");
  done_off_a: assert property ($rose(transmitIrq) |-> !rfOut.xtalPllEnable && !rfOut.paEnable)
    else $error("completion irq while radio powered");
endmodule

bind rfsq_sequencer rfsq_sequencer_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (
  .sys_clk(sys_clk),
  .reset(reset),
  .read(read),
  .write(write),
  .waitrequest(waitrequest),
  .lowFreqReceiverActive(lowFreqReceiverActive),
  .sensorMeasureActive(sensorMeasureActive),
  .cpuActive(cpuActive),
  .rfOut(rfOut),
  .mediumFreqOscEnable(mediumFreqOscEnable),
  .transmitIrq(transmitIrq)
);
`default_nettype wire

// file: test/rfsq_xtal_stage_model.sv
// Purpose: crystal divider and output stage seen from the sequencer
// Assumes: tick period DIV cycles, or twice that when slow
// Notes: divider held cleared at zero while the crystal is off
`timescale 1ns/1ps
`default_nettype none

module rfsq_xtal_stage_model #(
  parameter int DIV = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // pacing and sequencer drive
  input wire logic slow,
  input wire rfsq_pkg::rfsq_rf_t rfIn,
  // half-bit tick
  output logic dataHalfTick
);
  logic [7:0] divCnt;
  logic [7:0] divLast;
  assign divLast = slow ? 8'(2 * DIV - 1) : 8'(DIV - 1);

  // ==========
  // divider clocked from the crystal only while it is powered
  always_ff @(posedge sys_clk) begin
    if (reset || !rfIn.xtalPllEnable) begin
      divCnt <= 8'h00;
      dataHalfTick <= 1'b0;
    end else begin
      divCnt <= (divCnt == divLast) ? 8'h00 : divCnt + 8'h01;
      dataHalfTick <= (divCnt == divLast);
    end
  end
endmodule
`default_nettype wire

// file: test/test_rf_frame_transmit_sequencer.sv
// Purpose: self-checking bench of the radio frame sequencer
// Assumes: stage model makes half-bit ticks, long counts shortened
// Notes: xorshift stimulus from a fixed seed
`timescale 1ns/1ps
`default_nettype none

module test_rf_frame_transmit_sequencer;
  logic sys_clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, slow = 1'b0;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h00000000, readdata, q, r, act;
  logic [3:0] byteenable = 4'hF;
  logic waitrequest, dataHalfTick, mediumFreqOscEnable, transmitIrq;
  logic lowFreqReceiverActive = 1'b0, sensorMeasureActive = 1'b0, cpuActive = 1'b0;
  logic t1 = 1'b0, paPrev = 1'b0, xtalPrev = 1'b0;
  rfsq_pkg::rfsq_rf_t rfOut;
  logic [31:0] seed = 32'hA483;
  logic [255:0] bufImg;
  logic obs[$];
  int n_mismatch = 0, check_count = 0, paRise = 0, xtalFall = 0, n;

  always #50 sys_clk = ~sys_clk;

  rfsq_sequencer #(.MS_CYCLES(20), .SETTLE_CYCLES(8)) uut (.sys_clk(sys_clk), .reset(reset),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .dataHalfTick(dataHalfTick),
    .lowFreqReceiverActive(lowFreqReceiverActive), .sensorMeasureActive(sensorMeasureActive),
    .cpuActive(cpuActive), .rfOut(rfOut), .mediumFreqOscEnable(mediumFreqOscEnable),
    .transmitIrq(transmitIrq));
  rfsq_xtal_stage_model #(.DIV(4)) partner (.sys_clk(sys_clk), .reset(reset), .slow(slow),
    .rfIn(rfOut), .dataHalfTick(dataHalfTick));

  // ==========
  // helpers
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected halves {first, second}; bi-phase uses the observed line level
  function automatic logic [1:0] enc(input logic [1:0] code, input logic b, input logic prev, input logic first);
    case (code)
      2'h0: return {~b, b};
      2'h1: return {~prev, first ^ ~b};
      default: return {b, b};
    endcase
  endfunction

  // control word: misc is {irq, page, invert, data, powerdown, eom, gap}
  function automatic logic [31:0] ctrl(input logic [1:0] code, input logic [7:0] len, input logic [3:0] fr,
      input logic [6:0] misc, input logic send);
    return {10'h000, len, fr, code, misc, send};
  endfunction

  // activity noise and half-bit capture one cycle after each tick taken while on
  always @(posedge sys_clk) begin
    act = rnd();
    {lowFreqReceiverActive, sensorMeasureActive, cpuActive} <= act[2:0] & {3{act[3]}};
    t1 <= dataHalfTick && rfOut.paEnable;
    paPrev <= rfOut.paEnable;
    xtalPrev <= rfOut.xtalPllEnable;
    if (t1 && rfOut.paEnable) obs.push_back(rfOut.data);
    if (rfOut.paEnable && !paPrev) paRise++;
    if (!rfOut.xtalPllEnable && xtalPrev) xtalFall++;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic fail_wait();
    n_mismatch++;
    $display("[ERR] wait expected answer seen timeout");
    complete_run();
  endtask

  // one bus transfer, request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] qo);
    int k;
    k = 0;
    @(posedge sys_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do begin
      @(posedge sys_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 40);
    if (k >= 40) fail_wait();
    qo = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] exp, input string what);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(what, exp, x);
  endtask

  // start a datagram, poll for completion, compare the captured line
  task automatic run_tx(input logic [1:0] code, input logic [7:0] len, input logic [3:0] fr, input logic [6:0] misc);
    int k, halves;
    logic [1:0] h;
    obs.delete();
    paRise = 0;
    xtalFall = 0;
    halves = (int'(fr) + 1) * (2 * (int'(len) + 1) + 4 * misc[1]);
    wreg(rfsq_pkg::ADDR_CTRL, ctrl(code, len, fr, misc, 1'b1));
    k = 0;
    do begin
      bus(1'b0, rfsq_pkg::ADDR_CTRL, 32'h0, q); // reads control until send is seen clear
      k++;
    end while (q[0] !== 1'b0 && k < 3000);
    if (k >= 3000) fail_wait();
    repeat (2) @(posedge sys_clk);
    rchk(rfsq_pkg::ADDR_STATUS, 32'h1, "status after datagram");
    chk("completion irq", {31'h0, misc[6]}, {31'h0, transmitIrq});
    chk("frame count", 32'(fr) + 32'h1, paRise);
    chk("crystal stops", misc[2] ? 32'(fr) + 32'h1 : 32'h1, xtalFall);
    chk("half bits", halves, obs.size());
    if (obs.size() == halves) begin
      k = 0;
      for (int f = 0; f <= fr; f++) begin
        for (int i = 0; i <= len; i++) begin
          h = enc(code, bufImg[i], (i > 0) ? obs[k - 1] : 1'b0, obs[k]); // line idles low between frames
          chk("first half", {31'h0, h[1]}, {31'h0, obs[k]});
          chk("second half", {31'h0, h[0]}, {31'h0, obs[k + 1]});
          k += 2;
        end
        for (int e = 0; e < 4 * misc[1]; e++) chk("tail level", 32'h1, {31'h0, obs[k + e]});
        k += 4 * misc[1];
      end
    end
    wreg(rfsq_pkg::ADDR_STATUS, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk("irq after clear", 32'h0, {31'h0, transmitIrq});
    $display("transmit code %0d length %0d done", code, int'(len) + 1);
  endtask

  // ==========
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rchk(rfsq_pkg::ADDR_CTRL, 32'h0, "control at reset");
    rchk(rfsq_pkg::ADDR_STATUS, 32'h0, "status at reset");
    wreg(5'h0C, rnd());
    rchk(5'h0C, 32'h0, "unmapped read");
    for (int w = 0; w < 8; w++) begin
      bufImg[32 * w +: 32] = rnd();
      wreg(rfsq_pkg::ADDR_CTRL, ctrl(2'h0, 8'h00, 4'h0, {1'b0, w[2], 5'h00}, 1'b0));
      wreg(rfsq_pkg::ADDR_WINDOW + 5'(4 * (w % 4)), bufImg[32 * w +: 32]);
    end
    for (int w = 0; w < 8; w++) begin
      wreg(rfsq_pkg::ADDR_CTRL, ctrl(2'h0, 8'h00, 4'h0, {1'b0, w[2], 5'h00}, 1'b0));
      rchk(rfsq_pkg::ADDR_WINDOW + 5'(4 * (w % 4)), bufImg[32 * w +: 32], "window word");
    end
    $display("buffer pages done");
    wreg(rfsq_pkg::ADDR_TIMING, {10'h000, 1'b0, 6'h01, 7'h00, 8'h01});
    run_tx(2'h0, 8'h01, 4'h0, 7'b1000010);
    run_tx(2'h1, 8'h25, 4'h1, 7'b0000000);
    run_tx(2'h2, 8'hFF, 4'h0, 7'b1000010);
    r = rnd();
    slow <= 1'b1;
    wreg(rfsq_pkg::ADDR_TIMING, {10'h000, 1'b0, 6'h01, r[6:1], 1'b1, 8'h01});
    run_tx(2'h2, 8'h07, 4'h1, 7'b0000101);
    slow <= 1'b0;
    r = rnd();
    run_tx(2'(r[1:0] % 3), {2'b00, r[7:2]} | 8'h01, 4'h2, {5'h00, r[8], 1'b0});
    wreg(rfsq_pkg::ADDR_CTRL, ctrl(2'h3, 8'h00, 4'h0, 7'h00, 1'b1));
    n = 0;
    do begin
      bus(1'b0, rfsq_pkg::ADDR_STATUS, 32'h0, q);
      n++;
    end while (q[1] !== 1'b1 && n < 100);
    if (n >= 100) fail_wait();
    for (int v = 0; v < 4; v++) begin
      wreg(rfsq_pkg::ADDR_CTRL, ctrl(2'h3, 8'h00, 4'h0, {2'b00, v[1:0], 3'b000}, 1'b1));
      repeat (2) @(posedge sys_clk);
      chk("direct data", {31'h0, v[1] ^ v[0]}, {31'h0, rfOut.data});
      chk("direct amplifier", 32'h1, {31'h0, rfOut.paEnable});
    end
    wreg(rfsq_pkg::ADDR_CTRL, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("radio off after abort", 32'h0, {29'h0, rfOut});
    $display("direct mode done");
    complete_run();
  end
endmodule
`default_nettype wire

// file: verilog/rfsq_buffer_mem.sv
// Purpose: 256-bit transmit buffer, eight 32-bit words, byte writable
// Assumes: one write port, two read ports, all synchronous to sys_clk
// Notes: read data appear one clock after the address, from a register
`timescale 1ns/1ps
`default_nettype none

module rfsq_buffer_mem (
  // clock
  input wire logic sys_clk,
  // write port
  input wire logic writeEn,
  input wire logic [rfsq_pkg::BUF_AW-1:0] writeAddr,
  input wire logic [3:0] writeBytes,
  input wire logic [31:0] writeData,
  // bus read port
  input wire logic [rfsq_pkg::BUF_AW-1:0] busAddr,
  output logic [31:0] busData,
  // shifter read port
  input wire logic [rfsq_pkg::BUF_AW-1:0] txAddr,
  output logic [31:0] txData
);

  logic [31:0] words [rfsq_pkg::BUF_WORDS];

  // ==========================================================================
  // storage with byte lanes
  always_ff @(posedge sys_clk) begin
    for (int b = 0; b < 4; b++) begin
      if (writeEn && writeBytes[b]) begin
        words[writeAddr][b*8 +: 8] <= writeData[b*8 +: 8];
      end
    end
  end

  // registered reads
  always_ff @(posedge sys_clk) begin
    busData <= words[busAddr];
    txData <= words[txAddr];
  end

endmodule

`default_nettype wire

// file: verilog/rfsq_pkg.sv
// Purpose: shared constants and types of the radio frame transmit sequencer
// Assumes: 10 MHz system clock, 32-bit Avalon-MM register access
// Notes: register layouts are packed structs, high bits first in the word
package rfsq_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_TIME_US = 1000;
  localparam int SETTLE_TIME_US = 800;
  localparam int MS_CYCLES = (MS_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_RAND_SCALE = 40;
  localparam int TAIL_HALVES = 4;

  // ==========================================================================
  // register map (byte addresses)
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_TIMING = 5'h04;
  localparam logic [4:0] ADDR_STATUS = 5'h08;
  localparam logic [4:0] ADDR_WINDOW = 5'h10;
  localparam int WINDOW_WORDS = 4;
  localparam int BUF_WORDS = 8;
  localparam int BUF_AW = 3;

  // ==========================================================================
  // encodings and reset values
  localparam logic [1:0] CODE_DIRECT = 2'h3;
  localparam logic [6:0] LFSR_RESET = 7'h40;
  localparam logic [6:0] LFSR_TAPS = 7'h60;
  localparam int STAT_DONE = 0;
  localparam int STAT_READY = 1;
  localparam int STAT_BUSY = 2;

  typedef enum logic [1:0] {
    RFSQ_MANCHESTER,
    RFSQ_BIPHASE,
    RFSQ_NRZ
  } rfsq_kind_t;

  // control word, bits 21:0 of CTRL
  typedef struct packed {
    logic [7:0] frameBitCount;
    logic [3:0] framesPerDatagram;
    logic [1:0] encodeSelect;
    logic transmitIrqEnable;
    logic bufferPageSelect;
    logic directDataInvert;
    logic directData;
    logic interframePowerDown;
    logic endOfMessage;
    logic gapEnable;
    logic send;
  } rfsq_ctrl_t;

  // gap timer word, bits 21:0 of TIMING
  typedef struct packed {
    logic initialRandom;
    logic [5:0] frameTime;
    logic [6:0] lfsrSeed;
    logic [7:0] baseTime;
  } rfsq_timing_t;

  // drive towards the RF output stage
  typedef struct packed {
    logic xtalPllEnable;
    logic paEnable;
    logic data;
  } rfsq_rf_t;

endpackage

// file: verilog/rfsq_sequencer.sv
// Purpose: radio frame transmit sequencer with Avalon-MM registers
// Assumes: dataHalfTick is a one-cycle pulse at twice the bit rate, made
//   from the crystal, never on two adjacent cycles
// Notes: direct mode when the encode select field is all ones
//
// Summary of operation
// - buffer mode runs frames without processor help
// - medium clock enable follows send or activity
// - 256-bit buffer, eight-bit frame length field
// - send starts; bits encoded by select field
// - crystal and PLL settle before output
// - bit timing from crystal-derived half ticks
// - at end stop, output off, clear send
// - one to sixteen frames, amplifier off between
// - gaps timed by adders or omitted
// - interframe power down stops crystal and PLL in gaps
// - select all ones bypasses the encoder
// - invert bit flips direct data
// - frame of 1 to 256 bits plus tail
// - buffer seen as two 128-bit pages
// - least significant bit of lowest byte first
// - length is field plus one, from start
// - completion interrupt only when enabled
// - end of message adds two high bit times
`timescale 1ns/1ps
`default_nettype none

module rfsq_sequencer #(
  parameter int MS_CYCLES = rfsq_pkg::MS_CYCLES,
  parameter int SETTLE_CYCLES = rfsq_pkg::SETTLE_CYCLES,
  parameter logic [5:0] CODE_KIND_MAP = {rfsq_pkg::RFSQ_NRZ, rfsq_pkg::RFSQ_BIPHASE, rfsq_pkg::RFSQ_MANCHESTER}
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [rfsq_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // bit timing from the crystal divider
  input wire logic dataHalfTick,
  // activity of other blocks
  input wire logic lowFreqReceiverActive,
  input wire logic sensorMeasureActive,
  input wire logic cpuActive,
  // outputs
  output rfsq_pkg::rfsq_rf_t rfOut,
  output logic mediumFreqOscEnable,
  output logic transmitIrq
);

  typedef enum logic [2:0] {IDLE, GAP, WARM, DATA, TAIL, DIRECT} rfsq_state_t;

  rfsq_state_t state;
  rfsq_pkg::rfsq_ctrl_t ctrl;
  rfsq_pkg::rfsq_timing_t timing;
  logic transmitDoneFlag;
  logic outputStageReadyFlag;
  logic xtalWarm;
  logic [6:0] lfsr;
  logic [15:0] gapCount;
  logic [13:0] msCount;
  logic [13:0] settleCount;
  logic [7:0] bitIndex;
  logic halfPhase;
  logic currentBit;
  logic [2:0] tailCount;
  logic [3:0] frameIndex;
  logic busPhase;
  logic [31:0] memBusData;
  logic [31:0] memTxData;

  // merge written bytes into a register
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] lanes);
    logic [31:0] result;
    result = old;
    for (int b = 0; b < 4; b++) begin
      if (lanes[b]) begin
        result[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return result;
  endfunction

  // gap length in ms: base plus random (scaled only on the first gap when initialRandom is set) plus frame number adder
  function automatic logic [15:0] gapLength(input rfsq_pkg::rfsq_timing_t t, input logic [6:0] rnd,
                                            input logic initial_gap, input logic [3:0] frameNo);
    logic [15:0] randMs;
    logic [15:0] fnMs;
    randMs = (t.lfsrSeed == 7'h00) ? 16'h0000 : {9'h000, rnd};
    fnMs = 16'(t.frameTime * frameNo);
    if (initial_gap) begin
      fnMs = 16'h0000;
      if (t.initialRandom) begin
        randMs = 16'(randMs * rfsq_pkg::INIT_RAND_SCALE);
      end
    end
    return 16'(t.baseTime + randMs + fnMs);
  endfunction

  // level of one half bit for the selected line code
  function automatic logic encodeHalf(input logic [1:0] kind, input logic bitValue,
                                      input logic second, input logic prevLevel);
    logic level;
    level = bitValue;
    unique case (kind)
      rfsq_pkg::RFSQ_MANCHESTER: level = second ? bitValue : ~bitValue;
      rfsq_pkg::RFSQ_BIPHASE: level = second ? (prevLevel ^ ~bitValue) : ~prevLevel;
      default: level = bitValue;
    endcase
    return level;
  endfunction

  // ==========================================================================
  // bus decode
  wire busReq = read | write;
  wire busTake = busReq & ~waitrequest;
  wire selCtrl = address == rfsq_pkg::ADDR_CTRL;
  wire selTiming = address == rfsq_pkg::ADDR_TIMING;
  wire selStatus = address == rfsq_pkg::ADDR_STATUS;
  wire selWindow = address[4] == rfsq_pkg::ADDR_WINDOW[4];
  wire [rfsq_pkg::BUF_AW-1:0] windowAddr = {ctrl.bufferPageSelect, address[3:2]};
  wire writeCtrl = busTake & write & selCtrl;
  wire writeTiming = busTake & write & selTiming;
  wire writeStatus = busTake & write & selStatus;
  wire writeWindow = busTake & write & selWindow;
  wire [31:0] ctrlMerged = mergeBytes({10'h000, ctrl}, writedata, byteenable);
  wire [31:0] timingMerged = mergeBytes({10'h000, timing}, writedata, byteenable);
  wire [31:0] statusWord = {29'h0, state != IDLE, outputStageReadyFlag, transmitDoneFlag};
  wire [31:0] readMux = selCtrl ? {10'h000, ctrl} :
                        selTiming ? {10'h000, timing} :
                        selStatus ? statusWord :
                        selWindow ? memBusData : 32'h0000_0000;

  // ==========================================================================
  // sequencing decode
  wire directMode = ctrl.encodeSelect == rfsq_pkg::CODE_DIRECT;
  wire [1:0] codeKind = CODE_KIND_MAP[ctrl.encodeSelect*2 +: 2];
  wire msTick = msCount == 14'(MS_CYCLES - 1);
  wire settled = xtalWarm | (settleCount == 14'(SETTLE_CYCLES)); // crystal on a full settle time
  wire lastBit = bitIndex == ctrl.frameBitCount;
  wire lastFrame = frameIndex == ctrl.framesPerDatagram;
  wire bufferBit = memTxData[bitIndex[4:0]];
  wire [15:0] initGap = ctrl.gapEnable ? gapLength(timing, lfsr, 1'b1, 4'h0) : 16'h0000;
  wire [15:0] nextGap = ctrl.gapEnable ? gapLength(timing, lfsr, 1'b0, frameIndex + 4'h1) : 16'h0000;
  wire lfsrLoad = writeTiming & byteenable[1] & (writedata[14:8] != 7'h00);
  wire [6:0] next_lfsr = lfsr[0] ? ((lfsr >> 1) ^ rfsq_pkg::LFSR_TAPS) : (lfsr >> 1);
  wire startBuffer = state == IDLE && ctrl.send && !directMode;
  // last half bit stands one whole tick, then the optional tail halves
  wire [2:0] tailLast = ctrl.endOfMessage ? 3'(rfsq_pkg::TAIL_HALVES) : 3'h0;
  wire frameEnd = state == TAIL && dataHalfTick && tailCount == tailLast;
  wire datagramDone = frameEnd && lastFrame;
  wire softAbort = state != IDLE && !ctrl.send;

  // ==========================================================================
  // buffer memory, bus writes and the shifter's read port
  rfsq_buffer_mem u_mem (
    .sys_clk(sys_clk),
    .writeEn(writeWindow),
    .writeAddr(windowAddr),
    .writeBytes(byteenable),
    .writeData(writedata),
    .busAddr(windowAddr),
    .busData(memBusData),
    .txAddr(bitIndex[7:5]),
    .txData(memTxData)
  );

  // bus handshake: two wait cycles, answer registered
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      waitrequest <= 1'b1;
      busPhase <= 1'b0;
      readdata <= 32'h0000_0000;
    end else if (busTake) begin
      waitrequest <= 1'b1;
      busPhase <= 1'b0;
    end else if (busReq && busPhase) begin
      waitrequest <= 1'b0;
      readdata <= read ? readMux : 32'h0000_0000;
    end else if (busReq) begin
      busPhase <= 1'b1;
    end
  end

  // control register; hardware clears send at datagram end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl <= '0;
    end else if (writeCtrl) begin
      ctrl <= ctrlMerged[21:0];
    end else if (datagramDone) begin
      ctrl.send <= 1'b0;
    end
  end

  // gap timer register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timing <= '0;
    end else if (writeTiming) begin
      timing <= timingMerged[21:0];
    end
  end

  // done flag: set by completion, write one to clear, set wins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      transmitDoneFlag <= 1'b0;
    end else if (datagramDone) begin
      transmitDoneFlag <= 1'b1;
    end else if (writeStatus && byteenable[0] && writedata[rfsq_pkg::STAT_DONE]) begin
      transmitDoneFlag <= 1'b0;
    end
  end

  // interrupt request gated by its enable
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      transmitIrq <= 1'b0;
    end else begin
      transmitIrq <= transmitDoneFlag & ctrl.transmitIrqEnable;
    end
  end

  // medium clock request
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mediumFreqOscEnable <= 1'b0;
    end else begin
      mediumFreqOscEnable <= ctrl.send | lowFreqReceiverActive | sensorMeasureActive | cpuActive;
    end
  end

  // random source: seed on write, advance after each use
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lfsr <= rfsq_pkg::LFSR_RESET;
    end else if (lfsrLoad) begin
      lfsr <= writedata[14:8];
    end else if ((startBuffer || (frameEnd && !lastFrame)) && ctrl.gapEnable) begin
      lfsr <= next_lfsr;
    end
  end

  // millisecond divider, runs only while a gap is timed
  always_ff @(posedge sys_clk) begin
    if (reset || state != GAP || msTick) begin
      msCount <= 14'h0000;
    end else begin
      msCount <= msCount + 14'h0001;
    end
  end

  // crystal settle counter
  always_ff @(posedge sys_clk) begin
    if (reset || state != WARM || settled) begin
      settleCount <= 14'h0000;
    end else begin
      settleCount <= settleCount + 14'h0001;
    end
  end

  // ==========================================================================
  // frame sequencer, runs without software once send is set
  always_ff @(posedge sys_clk) begin
    if (reset || softAbort) begin
      state <= IDLE;
      rfOut <= '0;
      xtalWarm <= 1'b0;
      outputStageReadyFlag <= 1'b0;
      gapCount <= 16'h0000;
      bitIndex <= 8'h00;
      halfPhase <= 1'b0;
      currentBit <= 1'b0;
      tailCount <= 3'h0;
      frameIndex <= 4'h0;
    end else begin
      unique case (state)
        IDLE: begin
          frameIndex <= 4'h0;
          if (ctrl.send && directMode) begin
            state <= WARM;
          end else if (startBuffer && initGap != 16'h0000) begin
            state <= GAP;
            gapCount <= initGap;
          end else if (startBuffer) begin
            state <= WARM;
          end
        end
        GAP: begin
          rfOut.paEnable <= 1'b0;
          if (ctrl.interframePowerDown || frameIndex == 4'h0) begin
            rfOut.xtalPllEnable <= 1'b0;
            xtalWarm <= 1'b0;
          end
          if (gapCount == 16'h0000) begin
            state <= WARM;
          end else if (msTick) begin
            gapCount <= gapCount - 16'h0001;
          end
        end
        WARM: begin
          rfOut.xtalPllEnable <= 1'b1;
          if (settled) begin
            xtalWarm <= 1'b1;
            rfOut.paEnable <= 1'b1;
            bitIndex <= 8'h00;
            halfPhase <= 1'b0;
            state <= directMode ? DIRECT : DATA;
          end
        end
        DATA: begin
          if (dataHalfTick && !halfPhase) begin
            currentBit <= bufferBit;
            rfOut.data <= encodeHalf(codeKind, bufferBit, 1'b0, rfOut.data);
            halfPhase <= 1'b1;
          end else if (dataHalfTick) begin
            rfOut.data <= encodeHalf(codeKind, currentBit, 1'b1, rfOut.data);
            halfPhase <= 1'b0;
            if (!lastBit) begin
              bitIndex <= bitIndex + 8'h01;
            end else begin
              state <= TAIL;
              tailCount <= 3'h0;
            end
          end
        end
        TAIL: begin
          if (dataHalfTick) begin
            rfOut.data <= ctrl.endOfMessage;
            tailCount <= tailCount + 3'h1;
          end
        end
        DIRECT: begin
          outputStageReadyFlag <= 1'b1;
          rfOut.data <= ctrl.directData ^ ctrl.directDataInvert;
        end
      endcase
      // frame close: amplifier off, next gap, next frame or datagram end
      if (frameEnd) begin
        rfOut.paEnable <= 1'b0;
        rfOut.data <= 1'b0;
        frameIndex <= frameIndex + 4'h1;
        if (lastFrame) begin
          state <= IDLE;
          rfOut.xtalPllEnable <= 1'b0;
          xtalWarm <= 1'b0;
        end else if (nextGap != 16'h0000) begin
          state <= GAP;
          gapCount <= nextGap;
        end else begin
          state <= WARM;
        end
      end
    end
  end

endmodule

`default_nettype wire
